/* File: core/cmc_controller.v */
/*
  requester-side controller for a core memory unit: takes cycle orders over
  AXI4-Lite and drives request, mode, address and write-data lines.
  assumes memory pins are synchronous to clk and active levels as listed.
*/
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cmc_map.vh"

module cmc_controller #(
  parameter ADDR_W = 13,
  parameter DATA_W = 12,
  parameter TMR_W = 6
) (
  input wire clk, // 40 MHz clock
  input wire reset, // synchronous reset, active high
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  output reg readRequest_r, // read initiate to memory
  output reg writeRequest_r, // write initiate to memory
  output reg readOnly_r, // read-only mode line
  output reg fullCycleSelect_r, // full-cycle select line
  output reg [ADDR_W-1:0] memAddress_r, // address lines
  output reg [DATA_W-1:0] memWriteData_r, // write data lines
  output reg powerReady_r, // external supply-good drive
  input wire memoryAvailable, // memory idle, active high
  input wire dataValidN, // read data valid, active low
  input wire [DATA_W-1:0] memReadData // data output lines
);

  localparam [31:0] LINE_CYC = `CMC_LINE_CYC;
  localparam [31:0] DATA_CYC = `CMC_DATA_CYC;
  localparam [31:0] DROP_CYC = `CMC_DROP_CYC;
  localparam [31:0] SPACE_CYC = `CMC_SPACE_CYC;
  // request stands for the line hold time, well inside the drop limit
  localparam [31:0] REQ_CYC = (LINE_CYC < DROP_CYC) ? LINE_CYC : DROP_CYC;
  localparam [31:0] HOLD_CYC = (SPACE_CYC > DATA_CYC) ? SPACE_CYC : DATA_CYC;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARM = 2'h1;
  localparam [1:0] ST_DRIVE = 2'h2;
  localparam [1:0] ST_HOLD = 2'h3;

  reg [1:0] state_r;
  reg [2:0] op_r;
  reg [1:0] cfg_r;
  reg asyncWait_r;
  reg done_r;
  reg dataSeen_r;
  reg refused_r;
  reg [DATA_W-1:0] readData_r;
  reg [ADDR_W-1:0] addrReg_r;
  reg [DATA_W-1:0] wdataReg_r;
  wire [TMR_W-1:0] elapsed;
  wire timerStart;
  wire wrFire;
  wire rdFire;
  wire [31:0] laneMask;
  wire goWrite;
  wire accepted;
  wire isRead;
  wire cycleEnd;
  wire [31:0] statusWord;
  reg [31:0] rdMux;
  reg rdOk;

  // ==========================================================
  // elapsed time since zero time
  cmc_cycle_timer #(
    .WIDTH(TMR_W)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .start(timerStart),
    .count(elapsed)
  );

  // ==========================================================
  // AXI4-Lite slave handshakes
  assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rdFire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign laneMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign goWrite = s_axi_awready && (s_axi_awaddr == `CMC_REG_CTRL) &&
                   s_axi_wstrb[1] && s_axi_wdata[`CMC_CTRL_GO];
  assign accepted = goWrite && (state_r == ST_IDLE);

  always @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      s_axi_awready <= wrFire;
      s_axi_wready <= wrFire;
      s_axi_arready <= rdFire;
      if (s_axi_awready)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr <= `CMC_REG_CFG && s_axi_awaddr[1:0] == 2'h0) ?
                       2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // register writes
  always @(posedge clk)
  begin
    if (reset)
    begin
      addrReg_r <= `CMC_RST_ADDR;
      wdataReg_r <= `CMC_RST_WDATA;
      cfg_r <= `CMC_RST_CFG;
      op_r <= `CMC_RST_CTRL;
    end
    else if (s_axi_awready)
    begin
      case (s_axi_awaddr)
        `CMC_REG_CTRL:
        begin
          if (s_axi_wstrb[0] && state_r == ST_IDLE)
            op_r <= s_axi_wdata[`CMC_CTRL_OP_MSB:`CMC_CTRL_OP_LSB];
        end
        `CMC_REG_ADDR:
          addrReg_r <= (addrReg_r & ~laneMask[ADDR_W-1:0]) |
                       (s_axi_wdata[ADDR_W-1:0] & laneMask[ADDR_W-1:0]);
        `CMC_REG_WDATA:
          wdataReg_r <= (wdataReg_r & ~laneMask[DATA_W-1:0]) |
                        (s_axi_wdata[DATA_W-1:0] & laneMask[DATA_W-1:0]);
        `CMC_REG_CFG:
        begin
          if (s_axi_wstrb[0])
            cfg_r <= s_axi_wdata[1:0];
        end
        default:
          cfg_r <= cfg_r;
      endcase
    end
  end

  // ==========================================================
  // register reads
  assign statusWord = {27'h0, refused_r, memoryAvailable, dataSeen_r, done_r,
                       (state_r != ST_IDLE)};

  always @*
  begin
    rdOk = 1'b1;
    case (s_axi_araddr)
      `CMC_REG_CTRL: rdMux = {29'h0, op_r};
      `CMC_REG_ADDR: rdMux = {{(32-ADDR_W){1'b0}}, addrReg_r};
      `CMC_REG_WDATA: rdMux = {{(32-DATA_W){1'b0}}, wdataReg_r};
      `CMC_REG_STATUS: rdMux = statusWord;
      `CMC_REG_CFG: rdMux = {30'h0, cfg_r};
      `CMC_REG_RDATA: rdMux = {{(32-DATA_W){1'b0}}, readData_r};
      default:
      begin
        rdMux = 32'h00000000;
        rdOk = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // cycle sequencer
  assign isRead = (op_r != `CMC_OP_CLEAR_WRITE) && (op_r != `CMC_OP_SPLIT_WRITE);
  assign timerStart = (state_r == ST_ARM && (memoryAvailable || cfg_r[`CMC_CFG_ASYNC])) ||
                      (state_r == ST_DRIVE && asyncWait_r && !memoryAvailable);
  assign cycleEnd = (state_r == ST_HOLD) && (elapsed >= HOLD_CYC[TMR_W-1:0] - 1'b1) &&
                    (memoryAvailable || cfg_r[`CMC_CFG_ASYNC]);

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      readRequest_r <= 1'b0;
      writeRequest_r <= 1'b0;
      readOnly_r <= 1'b0;
      fullCycleSelect_r <= 1'b0;
      memAddress_r <= `CMC_RST_ADDR;
      memWriteData_r <= `CMC_RST_WDATA;
      asyncWait_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (accepted)
            state_r <= ST_ARM;
        end
        ST_ARM:
        begin
          if (memoryAvailable || cfg_r[`CMC_CFG_ASYNC])
          begin
            state_r <= ST_DRIVE;
            asyncWait_r <= !memoryAvailable;
            memAddress_r <= addrReg_r;
            // write data stands until next cycle
            memWriteData_r <= wdataReg_r;
            readRequest_r <= isRead;
            writeRequest_r <= !isRead;
            readOnly_r <= (op_r == `CMC_OP_READ_ONLY);
            fullCycleSelect_r <= (op_r != `CMC_OP_SPLIT_READ) &&
                                 (op_r != `CMC_OP_SPLIT_WRITE);
          end
        end
        ST_DRIVE:
        begin
          if (memoryAvailable)
            asyncWait_r <= 1'b0;
          if (!asyncWait_r && elapsed >= REQ_CYC[TMR_W-1:0] - 1'b1)
          begin
            readRequest_r <= 1'b0;
            writeRequest_r <= 1'b0;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (cycleEnd)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read data capture and sticky status
  always @(posedge clk)
  begin
    if (reset)
    begin
      readData_r <= {DATA_W{1'b0}};
      done_r <= 1'b0;
      dataSeen_r <= 1'b0;
      refused_r <= 1'b0;
      powerReady_r <= 1'b0;
    end
    else
    begin
      powerReady_r <= cfg_r[`CMC_CFG_PWR_READY];
      if (isRead && !asyncWait_r && !dataValidN &&
          (state_r == ST_DRIVE || state_r == ST_HOLD))
      begin
        readData_r <= memReadData;
        dataSeen_r <= 1'b1;
      end
      else if (s_axi_awready && s_axi_awaddr == `CMC_REG_STATUS &&
               s_axi_wstrb[0] && s_axi_wdata[`CMC_ST_DATA])
        dataSeen_r <= 1'b0;
      if (cycleEnd)
        done_r <= 1'b1;
      else if (s_axi_awready && s_axi_awaddr == `CMC_REG_STATUS &&
               s_axi_wstrb[0] && s_axi_wdata[`CMC_ST_DONE])
        done_r <= 1'b0;
      if (goWrite && state_r != ST_IDLE)
        refused_r <= 1'b1;
      else if (s_axi_awready && s_axi_awaddr == `CMC_REG_STATUS &&
               s_axi_wstrb[0] && s_axi_wdata[`CMC_ST_REFUSED])
        refused_r <= 1'b0;
    end
  end

endmodule // cmc_controller

/* File: core/cmc_map.vh */
/*
  register offsets, field positions, reset values and timing counts for
  the core memory cycle controller.
  assumes a 40 MHz clock and a 32-bit AXI4-Lite register port.
*/
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// ==========================================================
// register byte offsets
`define CMC_REG_CTRL 8'h00
`define CMC_REG_ADDR 8'h04
`define CMC_REG_WDATA 8'h08
`define CMC_REG_STATUS 8'h0c
`define CMC_REG_CFG 8'h10
`define CMC_REG_RDATA 8'h14

// ==========================================================
// fields
`define CMC_CTRL_OP_LSB 0
`define CMC_CTRL_OP_MSB 2
`define CMC_CTRL_GO 8
`define CMC_ST_BUSY 0
`define CMC_ST_DONE 1
`define CMC_ST_DATA 2
`define CMC_ST_AVAIL 3
`define CMC_ST_REFUSED 4
`define CMC_CFG_ASYNC 0
`define CMC_CFG_PWR_READY 1

// ==========================================================
// cycle type codes
`define CMC_OP_CLEAR_WRITE 3'h0
`define CMC_OP_READ_RESTORE 3'h1
`define CMC_OP_SPLIT_READ 3'h2
`define CMC_OP_SPLIT_WRITE 3'h3
`define CMC_OP_READ_ONLY 3'h4

// ==========================================================
// reset values
`define CMC_RST_CTRL 3'h0
`define CMC_RST_ADDR 13'h0000
`define CMC_RST_WDATA 12'h000
`define CMC_RST_CFG 2'h0

// ==========================================================
// timing, in ns, and derived counts
`define CMC_CLK_NS 25
`define CMC_REQ_HOLD_NS 75
`define CMC_LINE_HOLD_NS 100
`define CMC_DATA_HOLD_NS 150
`define CMC_REQ_DROP_NS 700
`define CMC_SPACING_NS 750
`define CMC_LINE_CYC ((`CMC_LINE_HOLD_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_DATA_CYC ((`CMC_DATA_HOLD_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_DROP_CYC (`CMC_REQ_DROP_NS / `CMC_CLK_NS)
`define CMC_SPACE_CYC ((`CMC_SPACING_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)

`endif

/* File: core/cmc_cycle_timer.v */
/*
  saturating elapsed-cycle counter, cleared by a start pulse.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module cmc_cycle_timer #(
  parameter WIDTH = 6
) (
  input wire clk, // system clock
  input wire reset, // synchronous reset, active high
  input wire start, // zero time: count restarts at 0
  output reg [WIDTH-1:0] count // cycles since last start
);

  // ==========================================================
  // counter
  always @(posedge clk)
  begin
    if (reset)
      count <= {WIDTH{1'b1}};
    else if (start)
      count <= {WIDTH{1'b0}};
    else if (count != {WIDTH{1'b1}})
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
  end

endmodule // cmc_cycle_timer

/* File: tb/cmc_controller_asserts.sv */
/*
  checker for the controller's memory pins and register handshakes.
  bound to every cmc_controller instance; one clock, reset active high.
*/
`timescale 1ns/1ps

module cmc_controller_asserts #(
  parameter ADDR_W = 13,
  parameter DATA_W = 12
) (
  input wire clk, // clock
  input wire reset, // reset
  input wire s_axi_awready, // aw ready
  input wire s_axi_wready, // w ready
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arready, // ar ready
  input wire s_axi_rvalid, // r valid
  input wire readRequest_r, // read initiate
  input wire writeRequest_r, // write initiate
  input wire readOnly_r, // read-only line
  input wire [ADDR_W-1:0] memAddress_r, // address lines
  input wire [DATA_W-1:0] memWriteData_r // write data lines
);
  reg rdPrev_r;
  reg wrPrev_r;
  reg [5:0] gap_r;
  wire reqRise = (readRequest_r & ~rdPrev_r) | (writeRequest_r & ~wrPrev_r);
  // ==========================================
  // cycles since the last request rose
  always @(posedge clk)
  begin
    rdPrev_r <= reset ? 1'b0 : readRequest_r;
    wrPrev_r <= reset ? 1'b0 : writeRequest_r;
    gap_r <= reset ? 6'h3f : reqRise ? 6'h00 : gap_r + {5'h0, gap_r != 6'h3f};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // assertions
  a_req_space: assert property (reqRise |-> gap_r >= 6'd29)
    else $error("requests closer than 750 ns");
  a_wreq_width: assert property ($rose(writeRequest_r) |-> writeRequest_r[*4])
    else $error("write request too short");
  a_rreq_drop: assert property ($rose(readRequest_r) |-> ##[1:28] !readRequest_r)
    else $error("read request not dropped by 700 ns");
  a_write_modes: assert property (writeRequest_r |-> !readRequest_r && !readOnly_r)
    else $error("mode lines wrong during write");
  a_wdata_hold: assert property ($rose(writeRequest_r) |=> $stable(memWriteData_r)[*5])
    else $error("write data moved within 150 ns");
  a_addr_hold: assert property (reqRise |=> $stable(memAddress_r)[*4])
    else $error("address moved within 100 ns");
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("awready and wready apart");
  a_bresp_order: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_rresp_order: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
endmodule // cmc_controller_asserts

bind cmc_controller cmc_controller_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_cmc_controller_asserts (.clk(clk), .reset(reset), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .readRequest_r(readRequest_r), .writeRequest_r(writeRequest_r), .readOnly_r(readOnly_r),
  .memAddress_r(memAddress_r), .memWriteData_r(memWriteData_r));

/* File: tb/cmc_mem_model.sv */
/*
  behavioural core memory unit: 12 planes of 8192 words, fixed strobe steps.
  assumes request and address lines synchronous to clk.
*/
`timescale 1ns/1ps

module cmc_mem_model (
  input wire clk, // clock
  input wire reset, // reset
  input wire readRequest, // read initiate
  input wire writeRequest, // write initiate
  input wire [12:0] addr, // address lines
  input wire [11:0] wdata, // write data lines
  output reg memoryAvailable, // idle, active high
  output reg dataValidN, // data valid, active low
  output wire [11:0] memReadData // data out lines
);
  reg [11:0] core [0:8191];
  reg [11:0] dataReg_r;
  reg [12:0] addr_r;
  reg [5:0] cnt_r;
  reg isWrite_r;
  assign memReadData = dataReg_r;
  always @(posedge clk)
  begin
    if (reset)
    begin
      memoryAvailable <= 1'b1;
      dataValidN <= 1'b1;
      dataReg_r <= 12'h000;
    end
    // whole address taken; start only while available
    else if (memoryAvailable)
    begin
      if (readRequest | writeRequest)
      begin
        addr_r <= addr;
        isWrite_r <= writeRequest;
        memoryAvailable <= 1'b0;
        cnt_r <= 6'h00;
      end
    end
    else
    begin
      cnt_r <= cnt_r + 6'h01;
      case (cnt_r)
        6'd2: dataReg_r <= isWrite_r ? wdata : 12'h000;
        6'd8: if (!isWrite_r) dataReg_r <= core[addr_r];
        6'd10: dataValidN <= isWrite_r;
        6'd14: dataValidN <= 1'b1;
        6'd20: core[addr_r] <= dataReg_r;
        6'd27: memoryAvailable <= 1'b1;
        default: ;
      endcase
    end
  end
endmodule // cmc_mem_model

/* File: tb/cmc_controller_tb.sv */
/*
  self-checking bench for the cycle controller with a memory model.
  assumes a 40 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "cmc_map.vh"

module cmc_controller_tb;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] awAddr = 8'h00;
  reg [31:0] wData = 32'h0;
  reg [7:0] arAddr = 8'h00;
  reg awValid = 1'b0;
  reg wValid = 1'b0;
  reg arValid = 1'b0;
  reg poll = 1'b0;
  wire awReady, wReady, bValid, arReady, rValid, rdReq, wrReq, rdOnly, fcSel, pwrRdy;
  wire memAvail, dvN;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [12:0] mAddr;
  wire [11:0] mWdata, mRdata;
  integer error_cnt = 0;
  integer checked = 0;
  integer seed = 32'h9ffa7369;
  integer i;
  reg [33:0] rdQ [$];
  reg [1:0] bQ [$];
  reg [31:0] got;
  reg [12:0] a;
  reg [11:0] d;
  reg [11:0] d2;
  always #12.5 clk = ~clk;

  cmc_controller u_cmc_controller (.clk(clk), .reset(reset), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(1'b1), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1),
    .readRequest_r(rdReq), .writeRequest_r(wrReq), .readOnly_r(rdOnly),
    .fullCycleSelect_r(fcSel), .memAddress_r(mAddr), .memWriteData_r(mWdata),
    .powerReady_r(pwrRdy), .memoryAvailable(memAvail), .dataValidN(dvN),
    .memReadData(mRdata));
  cmc_mem_model u_cmc_mem_model (.clk(clk), .reset(reset), .readRequest(rdReq),
    .writeRequest(wrReq), .addr(mAddr), .wdata(mWdata), .memoryAvailable(memAvail),
    .dataValidN(dvN), .memReadData(mRdata));

  // ==========================================
  // reporting
  task end_sim;
  begin
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task check(input [33:0] seen, input [33:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task fail;
  begin
    error_cnt = error_cnt + 1;
    $display("mismatch at %0t: wait timed out", $time);
    end_sim;
  end
  endtask
  // ==========================================
  // bus master
  task axiWrite(input [7:0] ad, input [31:0] dt, input [1:0] resp);
    integer n;
  begin
    bQ.push_back(resp);
    awAddr <= ad;
    wData <= dt;
    awValid <= 1'b1;
    wValid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (awReady === 1'b1)
        awValid <= 1'b0;
      if (wReady === 1'b1)
        wValid <= 1'b0;
      n = n + 1;
    end
    while (n < 40 && bValid !== 1'b1);
    if (bValid !== 1'b1)
      fail;
  end
  endtask
  task axiRead(input [7:0] ad, input p, input [33:0] exp);
    integer n;
  begin
    poll <= p;
    if (!p)
      rdQ.push_back(exp);
    arAddr <= ad;
    arValid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (arReady === 1'b1)
        arValid <= 1'b0;
      n = n + 1;
    end
    while (n < 40 && rValid !== 1'b1);
    if (rValid !== 1'b1)
      fail;
    got = rData;
  end
  endtask
  // outputs compared against the oldest note
  always @(posedge clk)
  begin
    if (bValid === 1'b1)
      check({32'h0, bResp}, {32'h0, bQ.pop_front()});
    if (rValid === 1'b1 && !poll)
      check({rResp, rData}, rdQ.pop_front());
  end
  task runOp(input [2:0] op, input [33:0] st);
    integer n;
  begin
    axiWrite(`CMC_REG_CTRL, {23'h0, 1'b1, 5'h0, op}, 2'b00);
    got = 32'h0;
    for (n = 0; n < 30 && got[1] !== 1'b1; n = n + 1)
      axiRead(`CMC_REG_STATUS, 1'b1, 34'h0);
    if (n == 30)
      fail;
    axiRead(`CMC_REG_STATUS, 1'b0, st);
    axiWrite(`CMC_REG_STATUS, 32'h16, 2'b00);
  end
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset values, then one unmapped offset
    for (i = 0; i < 7; i = i + 1)
      axiRead({i[5:0], 2'b00}, 1'b0, i == 3 ? 34'h8 : i == 6 ? 34'h200000000 : 34'h0);
    axiWrite(8'h18, 32'h5, 2'b10);
    axiWrite(`CMC_REG_CFG, 32'h2, 2'b00);
    repeat (2) @(posedge clk);
    check({33'h0, pwrRdy}, 34'h1);
    for (i = 0; i < 3; i = i + 1)
    begin
      a = $random(seed);
      d = $random(seed);
      axiWrite(`CMC_REG_ADDR, {19'h0, a}, 2'b00);
      axiWrite(`CMC_REG_WDATA, {20'h0, d}, 2'b00);
      runOp(`CMC_OP_CLEAR_WRITE, 34'ha);
      check({21'h0, mAddr}, {21'h0, a});
      check({33'h0, fcSel}, 34'h1);
      check({22'h0, mWdata}, {22'h0, d});
      runOp(`CMC_OP_READ_RESTORE, 34'he);
      axiRead(`CMC_REG_RDATA, 1'b0, {22'h0, d});
      runOp(`CMC_OP_READ_ONLY, 34'he);
      check({33'h0, rdOnly}, 34'h1);
      axiRead(`CMC_REG_RDATA, 1'b0, {22'h0, d});
    end
    // split cycle with a long pause before the write half
    d2 = $random(seed);
    axiWrite(`CMC_REG_WDATA, {20'h0, d2}, 2'b00);
    runOp(`CMC_OP_SPLIT_READ, 34'he);
    check({33'h0, fcSel}, 34'h0);
    axiRead(`CMC_REG_RDATA, 1'b0, {22'h0, d});
    repeat (200) @(posedge clk);
    runOp(`CMC_OP_SPLIT_WRITE, 34'ha);
    runOp(`CMC_OP_READ_RESTORE, 34'he);
    axiRead(`CMC_REG_RDATA, 1'b0, {22'h0, d2});
    // second go while busy is refused
    axiWrite(`CMC_REG_CTRL, 32'h100, 2'b00);
    runOp(`CMC_OP_CLEAR_WRITE, 34'h1a);
    // asynchronous reinitiate mode
    axiWrite(`CMC_REG_CFG, 32'h3, 2'b00);
    runOp(`CMC_OP_READ_RESTORE, 34'he);
    axiRead(`CMC_REG_RDATA, 1'b0, {22'h0, d2});
    repeat (4) @(posedge clk);
    end_sim;
  end
endmodule // cmc_controller_tb
